// ==== verilog/vacs_target.sv ====
// Chain select and volume addressing logic of one flash target.
module vacs_target
    import vacs_pkg::*;
#(
    parameter int VOL_W = 4
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic chip_sel_n,
    input wire logic chain_enable_in,
    input wire logic cmd_latch,
    input wire logic addr_latch,
    input wire logic data_latch,
    input wire logic [7:0] bus_in,
    input wire logic is_terminator,
    output logic chain_enable_out,
    output logic chain_enable_out_oe,
    output logic target_selected,
    output logic cmd_accept,
    output logic appointed,
    output logic sequential_init,
    output logic feature_busy,
    output logic [VOL_W-1:0] volume_address
);
    logic cs_n_s, en_s;
    logic appointed_q, appointed_d;
    logic [VOL_W-1:0] vol_q, vol_d, last_vsel_q, last_vsel_d;
    logic sel_q, sel_d, prev_sel_q, prev_sel_d;
    logic first_q, first_d, seq_q, seq_d, fresh_cs_q, fresh_cs_d;
    logic [7:0] high_cnt_q, high_cnt_d, busy_cnt_q, busy_cnt_d;
    vacs_cmd_state_type st_q, st_d;
    logic feat_vol_q, feat_vol_d;
    logic eo_q, eo_d, eoe_q, eoe_d, acc_q, acc_d, busy_q, busy_d;
    logic gate, cmd_ok, cs_fall, sel_eff;
    logic cs_prev_q;

    localparam logic [VOL_W-1:0] VACS_VOL_RESET = VOL_W'(VOL_ADDR_RESET);

    // Chip-select and chain enable come from pins and are synchronised.
    // Each synchroniser resets to its pin's idle level.
    vacs_sync #(
        .RST_LEVEL(1'b1)
    ) u_sync_cs (
        .clk_sys(clk_sys),
        .rst(rst),
        .pin_in(chip_sel_n),
        .level_out(cs_n_s)
    );
    vacs_sync #(
        .RST_LEVEL(1'b0)
    ) u_sync_en (
        .clk_sys(clk_sys),
        .rst(rst),
        .pin_in(chain_enable_in),
        .level_out(en_s)
    );

    // Once appointed the chain input no longer gates commands.
    assign gate = !cs_n_s && (appointed_q || en_s);
    // A fresh select low judges its first command by the last volume select.
    assign sel_eff = (fresh_cs_q && appointed_q && bus_in != CMD_VOLUME_SELECT)
        ? (last_vsel_q == vol_q) : sel_q;
    // Volume select itself must pass, or a deselected target could never return.
    assign cmd_ok = gate && (busy_cnt_q == 8'h00)
        && (!appointed_q || sel_eff || bus_in == CMD_VOLUME_SELECT);
    assign cs_fall = cs_prev_q && !cs_n_s;

    // Next-state logic for appointment, selection and decode.
    always_comb begin
        appointed_d = appointed_q;
        vol_d = vol_q;
        last_vsel_d = last_vsel_q;
        sel_d = sel_q;
        prev_sel_d = prev_sel_q;
        first_d = first_q;
        seq_d = seq_q;
        fresh_cs_d = fresh_cs_q;
        st_d = st_q;
        feat_vol_d = feat_vol_q;
        busy_cnt_d = (busy_cnt_q != 8'h00) ? busy_cnt_q - 8'h01 : 8'h00;
        high_cnt_d = cs_n_s ? ((high_cnt_q != 8'hff) ? high_cnt_q + 8'h01 : high_cnt_q) : 8'h00;
        acc_d = 1'b0;
        // Select high for the select high time restores earlier state.
        if (high_cnt_q == 8'(SELECT_HIGH_CYCLES - 1) && cs_n_s) begin
            sel_d = prev_sel_q;
            st_d = VACS_IDLE;
        end
        // On select fall a deselected appointed target stays deselected unless it is a terminator; other appointed targets are selected.
        if (cs_fall && appointed_q) begin
            prev_sel_d = sel_q;
            sel_d = 1'b1;
            fresh_cs_d = 1'b1;
            if (!sel_q && !is_terminator) begin
                sel_d = 1'b0;
            end
        end
        // The first command after a select fall settles reversion, taken or not.
        if (cmd_latch && gate && fresh_cs_q) begin
            fresh_cs_d = 1'b0;
            if (appointed_q && bus_in != CMD_VOLUME_SELECT) begin
                sel_d = sel_eff;
            end
        end
        if (cmd_latch && cmd_ok) begin
            acc_d = 1'b1;
            st_d = VACS_IDLE;
            if (first_q) begin
                first_d = 1'b0;
                seq_d = (bus_in == CMD_READ_STATUS);
            end
            unique case (bus_in)
                CMD_SET_FEATURES: st_d = VACS_FEAT_ADDR;
                CMD_VOLUME_SELECT: st_d = VACS_VSEL_ADDR;
                default: st_d = VACS_IDLE;  // Reset and hard reset keep volume state.
            endcase
        end else if (addr_latch && gate) begin
            unique case (st_q)
                VACS_FEAT_ADDR: begin
                    feat_vol_d = (bus_in == FEAT_VOLUME_CFG);
                    st_d = VACS_FEAT_DATA;
                end
                VACS_VSEL_ADDR: begin
                    last_vsel_d = bus_in[VOL_W-1:0];
                    sel_d = appointed_q && (bus_in[VOL_W-1:0] == vol_q);
                    prev_sel_d = sel_d;
                    st_d = VACS_IDLE;
                end
                default: st_d = VACS_IDLE;
            endcase
        end else if (data_latch && gate && st_q == VACS_FEAT_DATA) begin
            // First parameter byte carries the volume address.
            if (feat_vol_q && !appointed_q) begin
                vol_d = bus_in[VOL_W-1:0];
                appointed_d = 1'b1;
                sel_d = 1'b0;
                prev_sel_d = 1'b0;
                busy_cnt_d = 8'(FEATURE_BUSY_CYCLES);
            end
            st_d = VACS_IDLE;
        end
    end

    // Chain output: low at power-on, high once appointed, off when idle.
    // Next values are used so the output rises in the cycle the busy time ends.
    always_comb begin
        eoe_d = !cs_n_s;
        eo_d = appointed_d && (busy_cnt_d == 8'h00);
        busy_d = (busy_cnt_d != 8'h00);
    end

    // Only power-on reset clears appointment and address.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            appointed_q <= 1'b0;
            vol_q <= VACS_VOL_RESET;
            last_vsel_q <= VACS_VOL_RESET;
            sel_q <= 1'b0;
            prev_sel_q <= 1'b0;
            first_q <= 1'b1;
            seq_q <= 1'b0;
            fresh_cs_q <= 1'b0;
            st_q <= VACS_IDLE;
            feat_vol_q <= 1'b0;
            busy_cnt_q <= 8'h00;
            high_cnt_q <= 8'h00;
            busy_q <= 1'b0;
            eo_q <= 1'b0;
            eoe_q <= 1'b0;
            acc_q <= 1'b0;
            cs_prev_q <= 1'b1;
        end else begin
            appointed_q <= appointed_d;
            vol_q <= vol_d;
            last_vsel_q <= last_vsel_d;
            sel_q <= sel_d;
            prev_sel_q <= prev_sel_d;
            first_q <= first_d;
            seq_q <= seq_d;
            fresh_cs_q <= fresh_cs_d;
            st_q <= st_d;
            feat_vol_q <= feat_vol_d;
            busy_cnt_q <= busy_cnt_d;
            high_cnt_q <= high_cnt_d;
            busy_q <= busy_d;
            eo_q <= eo_d;
            eoe_q <= eoe_d;
            acc_q <= acc_d;
            cs_prev_q <= cs_n_s;
        end
    end

    assign chain_enable_out = eo_q;
    assign chain_enable_out_oe = eoe_q;
    assign target_selected = sel_q;
    assign cmd_accept = acc_q;
    assign appointed = appointed_q;
    assign sequential_init = seq_q;
    assign feature_busy = busy_q;
    assign volume_address = vol_q;

    // Commands are never accepted while the chain input gates them off.
    AST_GATE: assert property (@(posedge clk_sys) disable iff (rst)
        (cmd_latch && !appointed_q && !en_s) |=> !acc_q)
        else $error("Command accepted with chain enable low.");

    AST_APPOINT_OUT: assert property (@(posedge clk_sys) disable iff (rst)
        ($rose(appointed_q) && !cs_n_s) |-> ##[1:20] eo_q)
        else $error("Chain output not raised after appointment.");

    AST_DESEL: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(appointed_q) |-> !sel_q)
        else $error("Target still selected after appointment.");

    AST_KEEP: assert property (@(posedge clk_sys) disable iff (rst)
        appointed_q |=> appointed_q && $stable(vol_q))
        else $error("Volume appointment lost without power cycle.");

    AST_POWERON_LOW: assert property (@(posedge clk_sys) disable iff (rst)
        !appointed_q |-> !eo_q)
        else $error("Chain output high before appointment.");

    AST_FLOAT: assert property (@(posedge clk_sys) disable iff (rst)
        cs_n_s [*2] |-> !eoe_q)
        else $error("Chain output driven while deselected.");

    AST_VSEL: assert property (@(posedge clk_sys) disable iff (rst)
        (addr_latch && gate && st_q == VACS_VSEL_ADDR && appointed_q && !cmd_latch
         && bus_in[VOL_W-1:0] == vol_q) |=> sel_q)
        else $error("Matching volume select did not select target.");

    AST_SEQ: assert property (@(posedge clk_sys) disable iff (rst)
        (first_q && cmd_latch && cmd_ok && bus_in == CMD_READ_STATUS) |=> seq_q)
        else $error("Leading status not taken as sequential init.");
endmodule : vacs_target

// ==== verilog/vacs_pkg.sv ====
// Package for the volume addressing and chain select block.
package vacs_pkg;
    // Command opcodes seen on the command bus.
    localparam logic [7:0] CMD_RESET = 8'hff;
    localparam logic [7:0] CMD_HARD_RESET = 8'hfd;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_SET_FEATURES = 8'hef;
    localparam logic [7:0] CMD_VOLUME_SELECT = 8'he1;
    // Feature address that appoints the volume address.
    localparam logic [7:0] FEAT_VOLUME_CFG = 8'h58;
    // Clock rate and timing figures.
    localparam int CLK_PERIOD_NS = 100;
    localparam int SELECT_HIGH_TIME_NS = 100;
    localparam int SELECT_HIGH_CYCLES = (SELECT_HIGH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SELECT_LOW_MIN_NS = 100;
    localparam int SELECT_LOW_CYCLES = (SELECT_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FEATURE_BUSY_TIME_NS = 1000;
    localparam int FEATURE_BUSY_CYCLES = FEATURE_BUSY_TIME_NS / CLK_PERIOD_NS;
    localparam logic [3:0] VOL_ADDR_RESET = 4'h0;
    // Command decode stages.
    typedef enum logic [1:0] {
        VACS_IDLE = 2'b00,
        VACS_FEAT_ADDR = 2'b01,
        VACS_FEAT_DATA = 2'b11,
        VACS_VSEL_ADDR = 2'b10
    } vacs_cmd_state_type;
endpackage : vacs_pkg

// ==== verilog/vacs_sync.sv ====
// Three-stage synchroniser with agreement filter for a pin input.
module vacs_sync #(
    parameter logic RST_LEVEL = 1'b0
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic pin_in,
    output logic level_out
);
    logic s1_q, s2_q, s3_q, lvl_q, lvl_d;

    // A change is accepted once the second and third stages agree.
    always_comb begin
        lvl_d = lvl_q;
        if (s2_q == s3_q) begin
            lvl_d = s2_q;
        end
    end

    // The first stage feeds only the second one.
    // Resetting to the pin's idle level keeps a false edge from following reset.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s1_q <= RST_LEVEL;
            s2_q <= RST_LEVEL;
            s3_q <= RST_LEVEL;
            lvl_q <= RST_LEVEL;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            lvl_q <= lvl_d;
        end
    end

    assign level_out = lvl_q;
endmodule : vacs_sync

// ==== tb/vacs_host_model.sv ====
// Host controller model that drives chip select and the command bus of one target.
module vacs_host_model (
    input wire logic clk_sys,
    output logic chip_sel_n,
    output logic cmd_latch,
    output logic addr_latch,
    output logic data_latch,
    output logic [7:0] bus_in
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle levels; the bus holds a junk pattern until the first transfer.
    initial begin
        chip_sel_n = 1'b1;
        cmd_latch = 1'b0;
        addr_latch = 1'b0;
        data_latch = 1'b0;
        bus_in = 8'ha5;
    end

    // One bus cycle: kind 0 is a command, 1 an address, 2 a data byte.
    task automatic xfer(input logic [1:0] kind, input logic [7:0] b);
        @(posedge clk_sys);
        cmd_latch <= (kind == 2'h0);
        addr_latch <= (kind == 2'h1);
        data_latch <= (kind == 2'h2);
        bus_in <= b; // One target per call, never the same command to two.
        @(posedge clk_sys);
        cmd_latch <= 1'b0;
        addr_latch <= 1'b0;
        data_latch <= 1'b0;
        bus_in <= ~b; // Released bus is inverted so a stale byte never looks valid.
        #1;
    endtask : xfer

    // Select change, then a settle time covering the pin synchroniser and the low time.
    task automatic select(input logic low);
        @(posedge clk_sys);
        chip_sel_n <= ~low;
        repeat (5) @(posedge clk_sys);
        #1;
    endtask : select
endmodule : vacs_host_model

// ==== tb/vacs_target_tb.sv ====
// Self-checking testbench for the chain select and volume addressing target.
module vacs_target_tb
    import vacs_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic chain_enable_in = 1'b0;
    logic is_terminator = 1'b0;
    logic chip_sel_n, cmd_latch, addr_latch, data_latch;
    logic [7:0] bus_in;
    logic chain_enable_out, chain_enable_out_oe, target_selected, cmd_accept;
    logic appointed, sequential_init, feature_busy;
    logic [3:0] volume_address;
    int n_fail = 0;
    int n_compared = 0;
    int cyc = 0;
    int n;

    // Free-running 10 MHz clock.
    always #50 clk_sys = ~clk_sys;

    vacs_host_model host (.clk_sys(clk_sys), .chip_sel_n(chip_sel_n), .cmd_latch(cmd_latch),
        .addr_latch(addr_latch), .data_latch(data_latch), .bus_in(bus_in));

    vacs_target #(.VOL_W(4)) uut (.clk_sys(clk_sys), .rst(rst), .chip_sel_n(chip_sel_n),
        .chain_enable_in(chain_enable_in), .cmd_latch(cmd_latch), .addr_latch(addr_latch),
        .data_latch(data_latch), .bus_in(bus_in), .is_terminator(is_terminator),
        .chain_enable_out(chain_enable_out), .chain_enable_out_oe(chain_enable_out_oe),
        .target_selected(target_selected), .cmd_accept(cmd_accept), .appointed(appointed),
        .sequential_init(sequential_init), .feature_busy(feature_busy),
        .volume_address(volume_address));

    task automatic print_verdict();
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t ns: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // A hang is cut short well above the expected run length of under two hundred cycles.
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            $display("Error at %0t ns: run did not finish", $time);
            print_verdict();
        end
    end

    task automatic do_reset();
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask : do_reset

    // The chain input passes a synchroniser, so give it time to land.
    task automatic set_chain(input logic v);
        @(posedge clk_sys);
        chain_enable_in <= v;
        repeat (5) @(posedge clk_sys);
        #1;
    endtask : set_chain

    task automatic cmd(input logic [7:0] b);
        host.xfer(2'h0, b);
    endtask : cmd

    task automatic t_gating();
        host.select(1'b1);
        cmd(CMD_READ_STATUS);
        check(8'(cmd_accept), 8'h0);
        host.select(1'b0);
        set_chain(1'b1);
        cmd(CMD_READ_STATUS);
        check(8'(cmd_accept), 8'h0);
        host.select(1'b1);
        cmd(CMD_READ_STATUS);
        check(8'(cmd_accept), 8'h1);
        check(8'(sequential_init), 8'h1);
        set_chain(1'b0);
        cmd(CMD_RESET);
        check(8'(cmd_accept), 8'h0);
        set_chain(1'b1);
        cmd(CMD_RESET);
        check(8'(cmd_accept), 8'h1);
        $display("gating test done");
    endtask : t_gating

    task automatic t_appoint();
        cmd(CMD_SET_FEATURES);
        host.xfer(2'h1, FEAT_VOLUME_CFG);
        host.xfer(2'h2, 8'h05);
        check(8'(appointed), 8'h1);
        check(8'(target_selected), 8'h0);
        check(8'(volume_address), 8'h05);
        check(8'(feature_busy), 8'h1);
        cmd(CMD_READ_STATUS);
        check(8'(cmd_accept), 8'h0);
        n = 0;
        while (feature_busy === 1'b1 && n < 40) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        // Two edges pass between loading the busy count and the first poll.
        check(8'(n), 8'(FEATURE_BUSY_CYCLES - 2));
        check(8'(chain_enable_out), 8'h1);
        check(8'(chain_enable_out_oe), 8'h1);
        host.select(1'b0);
        check(8'(chain_enable_out_oe), 8'h0);
        $display("appoint test done");
    endtask : t_appoint

    // Volume select by address, then one idle clock for the selection to land.
    task automatic vsel(input logic [7:0] v);
        cmd(CMD_VOLUME_SELECT);
        host.xfer(2'h1, v);
        @(posedge clk_sys);
        #1;
    endtask : vsel

    task automatic t_select();
        host.select(1'b1);
        vsel(8'h05);
        check(8'(target_selected), 8'h1);
        set_chain(1'b0);
        cmd(CMD_READ_STATUS);
        check(8'(cmd_accept), 8'h1);
        vsel(8'h03);
        check(8'(target_selected), 8'h0);
        cmd(CMD_READ_STATUS);
        check(8'(cmd_accept), 8'h0);
        $display("select test done");
    endtask : t_select

    // A deselected terminator is selected again when select falls after another volume was picked.
    task automatic t_term();
        @(posedge clk_sys);
        is_terminator <= 1'b1;
        host.select(1'b0);
        host.select(1'b1);
        check(8'(target_selected), 8'h1);
        @(posedge clk_sys);
        is_terminator <= 1'b0;
        $display("terminator test done");
    endtask : t_term

    task automatic t_revert(input logic exp);
        host.select(1'b0);
        host.select(1'b1);
        check(8'(target_selected), 8'(exp));
        cmd(CMD_READ_STATUS);
        @(posedge clk_sys);
        #1;
        check(8'(target_selected), 8'(exp));
        $display("reversion test done");
    endtask : t_revert

    task automatic t_hard();
        cmd(CMD_HARD_RESET);
        check(8'(cmd_accept), 8'h1);
        repeat (4) @(posedge clk_sys);
        #1;
        check(8'(appointed), 8'h1);
        check(8'(volume_address), 8'h05);
        do_reset();
        check(8'(appointed), 8'h0);
        check(8'(volume_address), 8'h00);
        check(8'(chain_enable_out), 8'h0);
        // Let the held-low select pass the synchroniser, so only the chain input gates.
        host.select(1'b1);
        cmd(CMD_READ_STATUS);
        check(8'(cmd_accept), 8'h0);
        $display("hard reset and power cycle test done");
    endtask : t_hard

    initial begin
        do_reset();
        t_gating();
        t_appoint();
        t_select();
        t_term();
        t_revert(1'b0);
        vsel(8'h05);
        t_revert(1'b1);
        t_hard();
        print_verdict();
    end
endmodule : vacs_target_tb
